/* src/four_level_interrupt_controller.sv */
/*
 * four level interrupt controller: thirteen sources, per source enable
 * and two bit level, global enable, nesting by strictly higher level,
 * and wake from idle or power-down on external requests.
 * assumes the core pulses instr_start at each instruction boundary,
 * pulses reti_done when a service routine returns, and that peripheral
 * requests are levels on core_clk. source 0 is the top polling rank.
 */
`default_nettype none
`include "irq_ctrl_defs.svh"
// Overview of operation
// - four priority levels decide servicing order and preemption.
// - two pin variant has thirteen sources including both external pins.
// - single pin variant swaps external pin one for a serial interface.
// - each source has its own enable; disabled sources never serviced.
// - global enable clear blocks every source.
// - each source picks one of four levels via four priority registers.
// - a running routine is preempted only by strictly higher level.
// - a routine at the top level is never preempted.
// - pending requests are judged at instruction start; higher level wins.
// - ties inside one level go by fixed polling order.
// - each external pin selects level or edge trigger.
// - edge mode flags a high sample followed by a low one.
// - enabled external request wakes the core from idle or power-down.
module four_level_interrupt_controller
#(
	parameter bit SINGLE_EXT_PIN = 1'b0
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// external pins, active low
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	// peripheral requests, one per source; external slots ignored, except the pin b slot in the single pin variant
	input wire irq_ctrl_pkg::src_vec_t periph_req,
	// configuration
	input wire logic [7:0] irq_enable_reg_a,
	input wire logic [7:0] irq_enable_reg_b,
	input wire logic [7:0] priority_low_reg_a,
	input wire logic [7:0] priority_high_reg_a,
	input wire logic [7:0] priority_low_reg_b,
	input wire logic [7:0] priority_high_reg_b,
	input wire logic ext_pin_a_trigger_select,
	input wire logic ext_pin_b_trigger_select,
	// core handshake
	input wire logic instr_start,
	input wire logic reti_done,
	input wire logic sleep_enter,
	// to the core
	output logic irq_take,
	output irq_ctrl_pkg::src_id_t irq_source,
	output irq_ctrl_pkg::level_t active_level,
	output logic in_service,
	output logic wake,
	output logic ext_irq_request_flag_a,
	output logic ext_irq_request_flag_b
);
	import irq_ctrl_pkg::*;

	localparam int NLVL = 4;

	logic req_a;
	logic req_b;
	logic ack_a;
	logic ack_b;
	src_vec_t enables;
	src_vec_t prio_lo;
	src_vec_t prio_hi;
	src_vec_t pending;
	logic [NLVL-1:0] active_stack;
	logic [NLVL-1:0] next_active_stack;
	logic next_take;
	src_id_t next_source;
	level_t next_level;
	level_t cur_level;
	logic cur_valid;
	power_e power;
	power_e next_power;
	logic next_wake;

	// level of one source from its two bits
	function automatic level_t src_level(input int i);
		src_level = {prio_hi[i], prio_lo[i]};
	endfunction

	// highest level with a routine in progress
	function automatic level_t top_active(input logic [NLVL-1:0] stk);
		top_active = '0;
		for (int k = 0; k < NLVL; k++)
			if (stk[k])
				top_active = level_t'(k);
	endfunction

	// global enable bit of the first enable register
	function automatic logic global_on();
		global_on = irq_enable_reg_a[7];
	endfunction

	// external pin front ends
	ext_pin_trigger u_pin_a
	(
		.core_clk(core_clk),
		.srst(srst),
		.ext_irq_pin(ext_irq_pin_a),
		.trigger_select(ext_pin_a_trigger_select),
		.vector_ack(ack_a),
		.ext_irq_request_flag(req_a)
	);
	ext_pin_trigger u_pin_b
	(
		.core_clk(core_clk),
		.srst(srst),
		.ext_irq_pin(ext_irq_pin_b),
		.trigger_select(ext_pin_b_trigger_select),
		.vector_ack(ack_b),
		.ext_irq_request_flag(req_b)
	);

	// vectoring clears the edge flag of the chosen pin
	assign ack_a = irq_take && irq_source == src_id_t'(`IRQ_SRC_EXT_A);
	assign ack_b = irq_take && irq_source == src_id_t'(`IRQ_SRC_EXT_B);

	// gather enables and priorities into per source vectors
	assign enables = {irq_enable_reg_b[5:0], irq_enable_reg_a[6:0]};
	assign prio_lo = {priority_low_reg_b[5:0], priority_low_reg_a[6:0]};
	assign prio_hi = {priority_high_reg_b[5:0], priority_high_reg_a[6:0]};

	// per source pending, external pins replace their slots
	genvar g;
	generate
		for (g = 0; g < `IRQ_NUM_SRC; g++)
		begin : g_pend
			logic raw;
			if (g == `IRQ_SRC_EXT_A)
				assign raw = req_a;
			else if (g == `IRQ_SRC_EXT_B)
				// single pin variant: slot carries the serial interface
				assign raw = SINGLE_EXT_PIN ? periph_req[g] : req_b;
			else
				assign raw = periph_req[g];
			assign pending[g] = raw && enables[g] && global_on();
		end
	endgenerate

	assign cur_level = top_active(active_stack);
	assign cur_valid = |active_stack;

	// arbitration at instruction start, nesting bookkeeping
	always_comb
	begin
		level_t best_lvl;
		logic found;
		best_lvl = '0;
		found = 1'b0;
		next_source = irq_source;
		next_take = 1'b0;
		next_level = cur_level;
		next_active_stack = active_stack;
		if (reti_done && cur_valid)
			next_active_stack[cur_level] = 1'b0;
		// strict greater keeps the lower index on ties
		for (int i = 0; i < `IRQ_NUM_SRC; i++)
			if (pending[i] && (!found || src_level(i) > best_lvl))
			begin
				found = 1'b1;
				best_lvl = src_level(i);
				next_source = src_id_t'(i);
			end
		// only a strictly higher level preempts; a top level routine is never preempted
		if (instr_start && found && !reti_done && power == RUN_ST &&
			(!cur_valid || (cur_level != `IRQ_TOP_LVL &&
			best_lvl > cur_level)))
		begin
			next_take = 1'b1;
			next_level = best_lvl;
			next_active_stack[best_lvl] = 1'b1;
		end
		else
			next_source = irq_source;
		if (reti_done || next_take)
			next_level = top_active(next_active_stack);
	end

	// power state and wake
	always_comb
	begin
		logic ext_wake;
		ext_wake = (pending[`IRQ_SRC_EXT_A]) ||
			(!SINGLE_EXT_PIN && pending[`IRQ_SRC_EXT_B]);
		next_power = power;
		next_wake = 1'b0;
		unique case (power)
			RUN_ST:
				if (sleep_enter)
					next_power = SLEEP_ST;
			SLEEP_ST:
				if (ext_wake)
				begin
					next_power = RUN_ST;
					next_wake = 1'b1;
				end
		endcase
	end

	// register the arbitration and power state
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			active_stack <= '0;
			irq_take <= 1'b0;
			irq_source <= '0;
			active_level <= '0;
			in_service <= 1'b0;
			power <= RUN_ST;
			wake <= 1'b0;
			ext_irq_request_flag_a <= 1'b0;
			ext_irq_request_flag_b <= 1'b0;
		end
		else
		begin
			active_stack <= next_active_stack;
			irq_take <= next_take;
			irq_source <= next_source;
			active_level <= next_level;
			in_service <= |next_active_stack;
			power <= next_power;
			wake <= next_wake;
			ext_irq_request_flag_a <= req_a;
			ext_irq_request_flag_b <= SINGLE_EXT_PIN ? 1'b0 : req_b;
		end
	end
endmodule
`default_nettype wire

/* common/irq_ctrl_defs.svh */
/*
 * constants for the four level interrupt controller: source count,
 * level width and source positions in the enable and priority vectors.
 * assumes it is included by bare name from package and design files.
 */
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

`define IRQ_NUM_SRC 13
`define IRQ_LVL_W 2
`define IRQ_SRC_W 4
`define IRQ_TOP_LVL 2'h3
`define IRQ_SRC_EXT_A 0
`define IRQ_SRC_EXT_B 2
`define IRQ_EN_RESET 8'h00
`define IRQ_PRIO_RESET 8'h00

`endif

/* common/irq_ctrl_pkg.sv */
/*
 * types shared by the interrupt controller files.
 * assumes irq_ctrl_defs.svh is on the include path.
 */
`default_nettype none
`include "irq_ctrl_defs.svh"
package irq_ctrl_pkg;
	typedef logic [`IRQ_LVL_W-1:0] level_t;
	typedef logic [`IRQ_SRC_W-1:0] src_id_t;
	typedef logic [`IRQ_NUM_SRC-1:0] src_vec_t;
	typedef enum logic [1:0]
	{
		RUN_ST = 2'b00,
		SLEEP_ST = 2'b01
	} power_e;
endpackage
`default_nettype wire

/* src/ext_pin_trigger.sv */
/*
 * one external interrupt pin: synchroniser, level or falling edge request.
 * assumes the pin is asynchronous to core_clk and active low.
 */
`default_nettype none
module ext_pin_trigger
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// pin and control
	input wire logic ext_irq_pin,
	input wire logic trigger_select,
	input wire logic vector_ack,
	// request out
	output logic ext_irq_request_flag
);
	logic sync_a;
	logic sync_b;
	logic prev_sample;
	logic edge_flag;
	logic next_edge_flag;
	logic next_request;

	// edge flag: set wins over the vector clear
	always_comb
	begin
		next_edge_flag = edge_flag;
		if (vector_ack)
			next_edge_flag = 1'b0;
		if (prev_sample && !sync_b)
			next_edge_flag = 1'b1;
		if (!trigger_select)
			next_edge_flag = 1'b0;
		next_request = trigger_select ? next_edge_flag : !sync_b;
	end

	// two stage sync, then a sample history and the request register
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			prev_sample <= 1'b1;
			edge_flag <= 1'b0;
			ext_irq_request_flag <= 1'b0;
		end
		else
		begin
			sync_a <= ext_irq_pin;
			sync_b <= sync_a;
			prev_sample <= sync_b;
			edge_flag <= next_edge_flag;
			ext_irq_request_flag <= next_request;
		end
	end
endmodule
`default_nettype wire

/* tb/core_model.sv */
/* cpu core stand-in: instruction boundary pulses.
 * assumes the bench raises run once reset is over. */
`default_nettype none
module core_model
(
	// clock and control
	input wire logic core_clk,
	input wire logic run,
	// boundary to the controller
	output logic instr_start
);
	timeunit 1ns;
	timeprecision 1ps;
	initial instr_start = 1'b0;
	// one boundary every second cycle, a two clock machine cycle
	always @(negedge core_clk)
		instr_start <= run & ~instr_start;
endmodule
`default_nettype wire

/* tb/irq_ctrl_asserts.sv */
/* port checks of the interrupt controller.
 * assumes the controller's port names and package types. */
`default_nettype none
module irq_ctrl_chk
(
	// watched ports
	input wire logic core_clk,
	input wire logic srst,
	input wire logic instr_start,
	input wire logic reti_done,
	input wire logic [7:0] irq_enable_reg_a,
	input wire logic irq_take,
	input wire irq_ctrl_pkg::src_id_t irq_source,
	input wire irq_ctrl_pkg::level_t active_level,
	input wire logic in_service,
	input wire logic wake
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// takes, levels and wake pulses
	property p_start;
		irq_take |-> $past(instr_start) && !$past(reti_done);
	endproperty
	a_start: assert property (p_start) else $error("take off boundary");
	property p_glob;
		irq_take |-> $past(irq_enable_reg_a[7]);
	endproperty
	a_glob: assert property (p_glob) else $error("take, global off");
	property p_top;
		irq_take |-> $past(active_level) != 2'h3;
	endproperty
	a_top: assert property (p_top) else $error("top preempted");
	property p_pre;
		irq_take && $past(in_service) |-> active_level > $past(active_level);
	endproperty
	a_pre: assert property (p_pre) else $error("bad preempt");
	property p_ret;
		reti_done && in_service |=> !in_service ||
			active_level < $past(active_level);
	endproperty
	a_ret: assert property (p_ret) else $error("return no pop");
	property p_lvl;
		$changed(active_level) |-> irq_take || $past(reti_done);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level moved");
	property p_src;
		!irq_take |-> $stable(irq_source);
	endproperty
	a_src: assert property (p_src) else $error("source moved");
	property p_wake;
		wake |=> !wake;
	endproperty
	a_wake: assert property (p_wake) else $error("wake too long");
endmodule
bind four_level_interrupt_controller irq_ctrl_chk u_chk
(
	.core_clk, .srst, .instr_start, .reti_done, .irq_enable_reg_a,
	.irq_take, .irq_source, .active_level, .in_service, .wake
);
`default_nettype wire

/* tb/four_level_interrupt_controller_tb_top.sv */
/* bench of the interrupt controller: arbitration, nesting, pins, wake.
 * assumes core_model gives instruction boundaries. */
`default_nettype none
module four_level_interrupt_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_ctrl_pkg::*;
	logic core_clk, srst, pa, pb, ta, tsb, ret, slp, run, st;
	logic tk, insv, wk, fa, fb, fb1;
	logic [7:0] ena, enb, pla, pha, plb, phb;
	src_vec_t req;
	src_id_t src;
	level_t lvl;
	int err_count, cmp_count;
	core_model core (.core_clk(core_clk), .run(run), .instr_start(st));
	four_level_interrupt_controller DUT
	(
		.core_clk(core_clk), .srst(srst), .ext_irq_pin_a(pa),
		.ext_irq_pin_b(pb), .periph_req(req), .irq_enable_reg_a(ena),
		.irq_enable_reg_b(enb), .priority_low_reg_a(pla),
		.priority_high_reg_a(pha), .priority_low_reg_b(plb),
		.priority_high_reg_b(phb), .ext_pin_a_trigger_select(ta),
		.ext_pin_b_trigger_select(tsb), .instr_start(st),
		.reti_done(ret), .sleep_enter(slp), .irq_take(tk),
		.irq_source(src), .active_level(lvl), .in_service(insv),
		.wake(wk), .ext_irq_request_flag_a(fa), .ext_irq_request_flag_b(fb)
	);
	// single pin variant on the same stimulus: pin b must stay silent
	four_level_interrupt_controller #(.SINGLE_EXT_PIN(1'b1)) single_pin_dut
	(
		.core_clk(core_clk), .srst(srst), .ext_irq_pin_a(pa),
		.ext_irq_pin_b(pb), .periph_req(req), .irq_enable_reg_a(ena),
		.irq_enable_reg_b(enb), .priority_low_reg_a(pla),
		.priority_high_reg_a(pha), .priority_low_reg_b(plb),
		.priority_high_reg_b(phb), .ext_pin_a_trigger_select(ta),
		.ext_pin_b_trigger_select(tsb), .instr_start(st),
		.reti_done(ret), .sleep_enter(slp), .irq_take(),
		.irq_source(), .active_level(), .in_service(),
		.wake(), .ext_irq_request_flag_a(), .ext_irq_request_flag_b(fb1)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// bounded wait for a take (w=0) or a wake (w=1)
	task wait_hi(input bit w);
		int i;
		i = 0;
		while ((w ? wk : tk) !== 1'b1 && i < 40)
		begin
			@(posedge core_clk);
			#1 i++;
		end
		chk(i < 40, 1);
		if (i == 40)
			end_of_test;
	endtask
	task take(input logic [7:0] s, input logic [7:0] l);
		wait_hi(0);
		chk(src, s);
		chk(lvl, l);
		chk(insv, 1);
		// let the take pulse pass so a following take sees a fresh one
		@(posedge core_clk);
		cyc(1);
	endtask
	task none(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			#1 chk(tk, 0);
		end
		cyc(1);
	endtask
	task reti;
		ret = 1'b1;
		cyc(1);
		ret = 1'b0;
		cyc(1);
	endtask
	// reset, then the scenarios
	initial
	begin
		{pa, pb, ta, tsb, ret, slp, run} = 7'h60;
		{ena, enb, pla, pha, plb, phb} = '0;
		req = '0;
		srst = 1'b1;
		cyc(8);
		srst = 1'b0;
		run = 1'b1;
		ena = 8'hfd;
		enb = 8'h3f;
		req = 13'h000a;
		take(3, 0);
		ena = 8'hff;
		none(6);
		reti;
		take(1, 0);
		req = '0;
		reti;
		$display("test tie done");
		pha = 8'h02;
		{plb, phb} = 16'h2020;
		req = 13'h1002;
		take(12, 3);
		none(6);
		req = 13'h0002;
		reti;
		take(1, 2);
		req = 13'h1002;
		take(12, 3);
		req = '0;
		reti;
		chk(lvl, 2);
		reti;
		chk(insv, 0);
		chk(lvl, 0);
		$display("test level done");
		ena = 8'h7f;
		req = 13'h0002;
		none(6);
		ena = 8'hff;
		take(1, 2);
		req = '0;
		reti;
		$display("test global done");
		ena = 8'h05;
		ta = 1'b1;
		tsb = 1'b1;
		pa = 1'b0;
		pb = 1'b0;
		cyc(6);
		chk(fa, 1);
		chk(fb, 1);
		chk(fb1, 0);
		pa = 1'b1;
		pb = 1'b1;
		ena = 8'h85;
		take(0, 0);
		cyc(1);
		chk(fa, 0);
		chk(fb, 1);
		reti;
		take(2, 0);
		cyc(1);
		chk(fb, 0);
		reti;
		$display("test edge done");
		ena = 8'hff;
		ta = 1'b0;
		slp = 1'b1;
		cyc(1);
		slp = 1'b0;
		req = 13'h0002;
		none(4);
		pa = 1'b0;
		wait_hi(1);
		take(1, 2);
		pa = 1'b1;
		req = '0;
		reti;
		$display("test wake done");
		end_of_test;
	end
endmodule
`default_nettype wire
